// ==== inc/agc_synth_test_regs.svh ====
// offsets, write masks, reset values and timing counts of the gain and synthesizer test bank
// assumes inclusion by bare name from the design file only
`ifndef AGC_SYNTH_TEST_REGS_SVH
`define AGC_SYNTH_TEST_REGS_SVH

`define GAIN_MODE_THRESHOLDS_ADDR      6'h24
`define GAIN_LOOP_TUNING_ADDR          6'h25
`define GAIN_STEP_DIFFERENCES_ADDR     6'h26
`define SYNTH_ARRAY_CALIBRATION_ADDR   6'h27
`define SYNTH_CALIBRATION_CONTROL_ADDR 6'h28

`define GAIN_MODE_THRESHOLDS_RESET      16'h3649
`define GAIN_LOOP_TUNING_RESET          16'h0854
`define GAIN_STEP_DIFFERENCES_RESET     16'h012a
`define SYNTH_ARRAY_CALIBRATION_RESET   16'h0210
`define SYNTH_CALIBRATION_CONTROL_RESET 16'h5002

`define GAIN_LOOP_TUNING_MASK          16'h7fff
`define GAIN_STEP_DIFFERENCES_MASK     16'h03ff
`define SYNTH_ARRAY_CALIBRATION_MASK   16'h0fe0
`define SYNTH_CALIBRATION_CONTROL_MASK 16'hffff

`define OSC_BANK_CAL_RESULT_RESET 5'h10

`define CAL_SHORT_NS 37000
`define CAL_LONG_NS  57000
`define MCLK_PERIOD_NS 25
`define CAL_SHORT_CYCLES (`CAL_SHORT_NS / `MCLK_PERIOD_NS)
`define CAL_LONG_CYCLES  (`CAL_LONG_NS / `MCLK_PERIOD_NS)

`endif

// ==== inc/agc_synth_test_pkg.sv ====
// types of the gain and synthesizer test bank
// assumes nothing beyond the header of constants
package agc_synth_test_pkg;
    typedef enum logic [1:0] {
        cal_idle,
        cal_run
    } cal_state_type;
endpackage : agc_synth_test_pkg

// ==== logic/agc_synth_test_regs.sv ====
// register bank for gain loop and synthesizer calibration tuning, plus its calibration sequencer
// assumes a word-wide register port on mclk and analog blocks that read the decoded fields
`timescale 1ns/1ps
`include "agc_synth_test_regs.svh"

// Behaviour
// - front-end gain-mode hysteresis, four bits at top of first register, resets 3
// - six-bit medium/high front-end threshold, resets 25, 2 dB units
// - six-bit low/medium front-end threshold, resets 9, 2 dB units
// - blanking on stage removal or never; under manual gain only when bit set
// - boost bit doubles peak detector bias current
// - two-bit gain settle wait selector, resets 1
// - three enables for digital, fixed-stage and variable-stage peak detectors
// - averaging window code 0..3 gives 8,16,32,64 samples, resets 1
// - six-bit gain target level in 2 dB steps, resets 20
// - five-bit medium-to-high gain difference, resets 9
// - five-bit low-to-medium gain difference, resets 10
// - settle extend bit doubles oscillator settling per calibration step
// - override enable applies five-bit override value instead of calibrated array
// - read-only array result from latest calibration, resets 16
// - skip bit limits calibration to receive entry or transmit-calibrate strobe
// - measure extend bit gives 57 us calibration, else 37 us; resets 1
// - four-bit current reference for calibration, resets 4
// - six-bit current constant, also second current override value
// - tuning source: loop filter or converter value, unless test input enabled
// - manual gain override replaces loop gain during receive
module agc_synth_test_regs #(
    parameter int unsigned CAL_SHORT_CYCLES = `CAL_SHORT_CYCLES,
    parameter int unsigned CAL_LONG_CYCLES  = `CAL_LONG_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    input  wire logic [5:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        rx_entry,
    input  wire logic        tx_entry,
    input  wire logic        transmit_calibrate_strobe,
    input  wire logic        manual_gain_override,
    input  wire logic        tuning_test_input_enable,
    input  wire logic        osc_current_override_enable,
    input  wire logic [4:0]  cal_array_found,
    input  wire logic        stage_removed,
    input  wire logic [6:0]  loop_gain,
    input  wire logic [6:0]  manual_gain,
    output logic      [6:0]  applied_gain,
    output logic             blank_now,
    output logic      [4:0]  osc_bank_applied,
    output logic             cal_busy,
    output logic             cal_done,
    output logic             osc_settle_extend,
    output logic      [6:0]  gain_average_samples,
    output logic             tuning_from_converter,
    output logic      [5:0]  current_override_b,
    output logic             current_override_b_en
);
    localparam int unsigned CNT_W = 16;

    logic [15:0] gain_mode_thresholds, next_gain_mode_thresholds;
    logic [15:0] gain_loop_tuning, next_gain_loop_tuning;
    logic [15:0] gain_step_differences, next_gain_step_differences;
    logic [15:0] synth_array_calibration, next_synth_array_calibration;
    logic [15:0] synth_calibration_control, next_synth_calibration_control;
    logic [4:0]  osc_bank_cal_result, next_osc_bank_cal_result;

    // named field views used by the analog side
    logic [3:0] front_gain_hysteresis;
    logic [5:0] front_gain_upper_threshold;
    logic [5:0] front_gain_lower_threshold;
    logic       gain_blanking_select;
    logic       detector_bias_double;
    logic [1:0] gain_settle_delay;
    logic [2:0] detector_enable_set;
    logic [1:0] gain_average_window;
    logic [5:0] gain_target_level;
    logic [4:0] mid_to_top_gain_delta;
    logic [4:0] bottom_to_mid_gain_delta;
    logic       osc_bank_override_enable;
    logic [4:0] osc_bank_override_value;
    logic       skip_transmit_calibration;
    logic       osc_measure_extend;
    logic [3:0] osc_current_reference;
    logic [5:0] osc_current_constant;
    logic       tuning_source_select;
    logic [2:0] tuning_converter_value;

    assign front_gain_hysteresis      = gain_mode_thresholds[15:12];
    assign front_gain_upper_threshold = gain_mode_thresholds[11:6];
    assign front_gain_lower_threshold = gain_mode_thresholds[5:0];
    assign gain_blanking_select       = gain_loop_tuning[14];
    assign detector_bias_double       = gain_loop_tuning[13];
    assign gain_settle_delay          = gain_loop_tuning[12:11];
    assign detector_enable_set        = gain_loop_tuning[10:8];
    assign gain_average_window        = gain_loop_tuning[7:6];
    assign gain_target_level          = gain_loop_tuning[5:0];
    assign mid_to_top_gain_delta      = gain_step_differences[9:5];
    assign bottom_to_mid_gain_delta   = gain_step_differences[4:0];
    assign osc_bank_override_enable   = synth_array_calibration[10];
    assign osc_bank_override_value    = synth_array_calibration[9:5];
    assign skip_transmit_calibration  = synth_calibration_control[15];
    assign osc_measure_extend         = synth_calibration_control[14];
    assign osc_current_reference      = synth_calibration_control[13:10];
    assign osc_current_constant       = synth_calibration_control[9:4];
    assign tuning_source_select       = synth_calibration_control[3];
    assign tuning_converter_value     = synth_calibration_control[2:0];

    // register write path; reserved bits are masked so they always read zero
    always_comb begin
        next_gain_mode_thresholds      = gain_mode_thresholds;
        next_gain_loop_tuning          = gain_loop_tuning;
        next_gain_step_differences     = gain_step_differences;
        next_synth_array_calibration   = synth_array_calibration;
        next_synth_calibration_control = synth_calibration_control;
        if (reg_wr) begin
            unique case (reg_addr)
                `GAIN_MODE_THRESHOLDS_ADDR: next_gain_mode_thresholds = reg_wdata;
                `GAIN_LOOP_TUNING_ADDR: next_gain_loop_tuning = reg_wdata & `GAIN_LOOP_TUNING_MASK;
                `GAIN_STEP_DIFFERENCES_ADDR: begin
                    next_gain_step_differences = reg_wdata & `GAIN_STEP_DIFFERENCES_MASK;
                end
                `SYNTH_ARRAY_CALIBRATION_ADDR: begin
                    next_synth_array_calibration = reg_wdata & `SYNTH_ARRAY_CALIBRATION_MASK;
                end
                `SYNTH_CALIBRATION_CONTROL_ADDR: next_synth_calibration_control = reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            gain_mode_thresholds      <= `GAIN_MODE_THRESHOLDS_RESET;
            gain_loop_tuning          <= `GAIN_LOOP_TUNING_RESET;
            gain_step_differences     <= `GAIN_STEP_DIFFERENCES_RESET;
            synth_array_calibration   <= `SYNTH_ARRAY_CALIBRATION_RESET;
            synth_calibration_control <= `SYNTH_CALIBRATION_CONTROL_RESET;
        end else if (clk_en) begin
            gain_mode_thresholds      <= next_gain_mode_thresholds;
            gain_loop_tuning          <= next_gain_loop_tuning;
            gain_step_differences     <= next_gain_step_differences;
            synth_array_calibration   <= next_synth_array_calibration;
            synth_calibration_control <= next_synth_calibration_control;
        end
    end

    // calibration sequencer
    agc_synth_test_pkg::cal_state_type cal_state, next_cal_state;
    logic [CNT_W-1:0] cal_count, next_cal_count;
    logic [CNT_W-1:0] cal_length;
    logic             cal_request;
    logic             next_cal_done;

    assign cal_request = rx_entry | (tx_entry & ~skip_transmit_calibration)
                       | (transmit_calibrate_strobe & skip_transmit_calibration);
    // settling is part of each step, so its extension adds to the total as well
    always_comb begin
        cal_length = osc_measure_extend ? CNT_W'(CAL_LONG_CYCLES) : CNT_W'(CAL_SHORT_CYCLES);
        if (osc_settle_extend)
            cal_length = cal_length + CNT_W'(CAL_SHORT_CYCLES / 8);
    end

    always_comb begin
        next_cal_state           = cal_state;
        next_cal_count           = cal_count;
        next_cal_done            = 1'b0;
        next_osc_bank_cal_result = osc_bank_cal_result;
        unique case (cal_state)
            agc_synth_test_pkg::cal_idle: begin
                if (cal_request) begin
                    next_cal_state = agc_synth_test_pkg::cal_run;
                    next_cal_count = cal_length - CNT_W'(1);
                end
            end
            agc_synth_test_pkg::cal_run: begin
                if (cal_count == '0) begin
                    next_cal_state           = agc_synth_test_pkg::cal_idle;
                    next_cal_done            = 1'b1;
                    next_osc_bank_cal_result = cal_array_found;
                end else begin
                    next_cal_count = cal_count - CNT_W'(1);
                end
            end
            default: next_cal_state = agc_synth_test_pkg::cal_idle;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cal_state           <= agc_synth_test_pkg::cal_idle;
            cal_count           <= '0;
            cal_done            <= 1'b0;
            osc_bank_cal_result <= `OSC_BANK_CAL_RESULT_RESET;
        end else if (clk_en) begin
            cal_state           <= next_cal_state;
            cal_count           <= next_cal_count;
            cal_done            <= next_cal_done;
            osc_bank_cal_result <= next_osc_bank_cal_result;
        end
    end

    // registered outputs toward the analog blocks
    logic [15:0] next_reg_rdata;
    logic [6:0]  next_applied_gain;
    logic        next_blank_now;
    logic [4:0]  next_osc_bank_applied;
    logic [6:0]  next_gain_average_samples;

    always_comb begin
        unique case (reg_addr)
            `GAIN_MODE_THRESHOLDS_ADDR:      next_reg_rdata = gain_mode_thresholds;
            `GAIN_LOOP_TUNING_ADDR:          next_reg_rdata = gain_loop_tuning;
            `GAIN_STEP_DIFFERENCES_ADDR:     next_reg_rdata = gain_step_differences;
            `SYNTH_ARRAY_CALIBRATION_ADDR:   next_reg_rdata = {synth_array_calibration[15:5], osc_bank_cal_result};
            `SYNTH_CALIBRATION_CONTROL_ADDR: next_reg_rdata = synth_calibration_control;
            default:                         next_reg_rdata = 16'h0000;
        endcase
        next_applied_gain = manual_gain_override ? manual_gain : loop_gain;
        // loop-driven blanking only happens when the loop removes a stage
        if (manual_gain_override)
            next_blank_now = gain_blanking_select;
        else
            next_blank_now = ~gain_blanking_select & stage_removed;
        next_osc_bank_applied = osc_bank_override_enable ? osc_bank_override_value : osc_bank_cal_result;
        next_gain_average_samples = 7'h08 << gain_average_window;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata             <= 16'h0000;
            applied_gain          <= 7'h00;
            blank_now             <= 1'b0;
            osc_bank_applied      <= `OSC_BANK_CAL_RESULT_RESET;
            cal_busy              <= 1'b0;
            osc_settle_extend     <= 1'b0;
            gain_average_samples  <= 7'h10;
            tuning_from_converter <= 1'b0;
            current_override_b    <= 6'h00;
            current_override_b_en <= 1'b0;
        end else if (clk_en) begin
            reg_rdata             <= next_reg_rdata;
            applied_gain          <= next_applied_gain;
            blank_now             <= next_blank_now;
            osc_bank_applied      <= next_osc_bank_applied;
            cal_busy              <= (next_cal_state == agc_synth_test_pkg::cal_run);
            osc_settle_extend     <= synth_array_calibration[11];
            gain_average_samples  <= next_gain_average_samples;
            tuning_from_converter <= ~tuning_test_input_enable & tuning_source_select;
            current_override_b    <= osc_current_constant;
            current_override_b_en <= osc_current_override_enable;
        end
    end

    property p_window;
        @(posedge mclk) disable iff (srst)
        clk_en |=> gain_average_samples == (7'h08 << $past(gain_average_window));
    endproperty
    a_window: assert property (p_window) else $error("window size wrong");

    property p_bank;
        @(posedge mclk) disable iff (srst)
        clk_en && osc_bank_override_enable |=> osc_bank_applied == $past(osc_bank_override_value);
    endproperty
    a_bank: assert property (p_bank) else $error("override not applied");

    property p_gain;
        @(posedge mclk) disable iff (srst)
        clk_en && manual_gain_override |=> applied_gain == $past(manual_gain);
    endproperty
    a_gain: assert property (p_gain) else $error("manual gain not applied");

    property p_blank;
        @(posedge mclk) disable iff (srst)
        clk_en && !manual_gain_override && gain_blanking_select |=> !blank_now;
    endproperty
    a_blank: assert property (p_blank) else $error("blanking when disabled");

    property p_skip;
        @(posedge mclk) disable iff (srst)
        clk_en && cal_state == agc_synth_test_pkg::cal_idle && skip_transmit_calibration
            && tx_entry && !rx_entry && !transmit_calibrate_strobe |=> cal_state == agc_synth_test_pkg::cal_idle;
    endproperty
    a_skip: assert property (p_skip) else $error("transmit calibration not skipped");

    property p_result;
        @(posedge mclk) disable iff (srst)
        clk_en && !(cal_state == agc_synth_test_pkg::cal_run && cal_count == '0) |=> $stable(osc_bank_cal_result);
    endproperty
    a_result: assert property (p_result) else $error("result changed outside completion");

    property p_tune;
        @(posedge mclk) disable iff (srst)
        clk_en && tuning_test_input_enable |=> !tuning_from_converter;
    endproperty
    a_tune: assert property (p_tune) else $error("tuning source wrong");

    property p_reserved;
        @(posedge mclk) disable iff (srst)
        gain_loop_tuning[15] == 1'b0 && gain_step_differences[15:10] == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    // a request seen while idle starts the sequencer at once
    sequence s_cal_start;
        clk_en && cal_state == agc_synth_test_pkg::cal_idle && cal_request;
    endsequence

    sequence s_cal_last;
        clk_en && cal_state == agc_synth_test_pkg::cal_run && cal_count == '0;
    endsequence

    property p_start;
        @(posedge mclk) disable iff (srst)
        s_cal_start |=> cal_busy && cal_state == agc_synth_test_pkg::cal_run;
    endproperty
    a_start: assert property (p_start) else $error("calibration did not start");

    property p_finish;
        @(posedge mclk) disable iff (srst)
        s_cal_last |=> cal_done && !cal_busy && osc_bank_cal_result == $past(cal_array_found);
    endproperty
    a_finish: assert property (p_finish) else $error("calibration did not complete");
endmodule : agc_synth_test_regs

// ==== verif/agc_synth_test_regs_tb.sv ====
// self-checking bench for the gain loop and synthesizer calibration register bank
// assumes the bank alone on mclk, inputs driven at falling edges, calibration counts shortened
`timescale 1ns/1ps

module agc_synth_test_regs_tb;
    localparam int unsigned SHORT_CYC = 8;
    localparam int unsigned LONG_CYC  = 12;

    logic        mclk;
    logic        srst;
    logic        clk_en;
    logic [5:0]  reg_addr;
    logic        reg_wr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        rx_entry;
    logic        tx_entry;
    logic        transmit_calibrate_strobe;
    logic        manual_gain_override;
    logic        tuning_test_input_enable;
    logic        osc_current_override_enable;
    logic [4:0]  cal_array_found;
    logic        stage_removed;
    logic [6:0]  loop_gain;
    logic [6:0]  manual_gain;
    logic [6:0]  applied_gain;
    logic        blank_now;
    logic [4:0]  osc_bank_applied;
    logic        cal_busy;
    logic        cal_done;
    logic        osc_settle_extend;
    logic [6:0]  gain_average_samples;
    logic        tuning_from_converter;
    logic [5:0]  current_override_b;
    logic        current_override_b_en;
    int          mismatches;
    int          total_checks;
    int          n_long;
    int          n_short;
    int          n_ext;
    int          n_tmp;
    logic [15:0] rd;
    // host leaves reserved bits zero; result field keeps its reset value
    logic [15:0] ones_wr  [5] = '{16'hffff, 16'h7fff, 16'h03ff, 16'h0fff, 16'hffff};
    logic [15:0] ones_exp [5] = '{16'hffff, 16'h7fff, 16'h03ff, 16'h0ff0, 16'hffff};

    agc_synth_test_regs #(
        .CAL_SHORT_CYCLES(SHORT_CYC),
        .CAL_LONG_CYCLES (LONG_CYC)
    ) i_agc_synth_test_regs (
        .mclk(mclk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_entry(rx_entry), .tx_entry(tx_entry),
        .transmit_calibrate_strobe(transmit_calibrate_strobe), .manual_gain_override(manual_gain_override),
        .tuning_test_input_enable(tuning_test_input_enable),
        .osc_current_override_enable(osc_current_override_enable), .cal_array_found(cal_array_found),
        .stage_removed(stage_removed), .loop_gain(loop_gain), .manual_gain(manual_gain),
        .applied_gain(applied_gain), .blank_now(blank_now), .osc_bank_applied(osc_bank_applied),
        .cal_busy(cal_busy), .cal_done(cal_done), .osc_settle_extend(osc_settle_extend),
        .gain_average_samples(gain_average_samples), .tuning_from_converter(tuning_from_converter),
        .current_override_b(current_override_b), .current_override_b_en(current_override_b_en)
    );

    always #12.5 mclk = ~mclk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_reg

    task automatic check_port(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_reg(got, exp, {"port ", what});
    endtask : check_port

    task automatic reg_write(input logic [5:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
    endtask : reg_write

    // read data is registered, so it is taken one cycle after the address
    task automatic reg_expect(input logic [5:0] a, input logic [15:0] exp, input string what);
        @(negedge mclk);
        reg_addr = a;
        @(negedge mclk);
        check_reg(reg_rdata, exp, what);
    endtask : reg_expect

    // kind 0 receive entry, 1 transmit entry, 2 transmit-calibrate strobe
    task automatic calibrate(input int kind, input logic go, input logic [4:0] found, output int n);
        logic seen;
        seen = 1'b0;
        n = 0;
        @(negedge mclk);
        cal_array_found           = found;
        rx_entry                  = (kind == 0);
        tx_entry                  = (kind == 1);
        transmit_calibrate_strobe = (kind == 2);
        @(negedge mclk);
        rx_entry                  = 1'b0;
        tx_entry                  = 1'b0;
        transmit_calibrate_strobe = 1'b0;
        while (!seen && n < 40) begin
            @(negedge mclk);
            n++;
            if (n == 1) check_port({15'h0, cal_busy}, {15'h0, go}, "busy");
            seen = (cal_done === 1'b1);
        end
        check_port({15'h0, seen}, {15'h0, go}, "calibration ran");
        check_port({15'h0, cal_busy}, 16'h0000, "busy after");
        @(negedge mclk);
        check_port({15'h0, cal_done}, 16'h0000, "done pulse");
    endtask : calibrate

    initial begin
        #(25 * 4000);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        mclk = 1'b0; srst = 1'b1; clk_en = 1'b1; reg_addr = 6'h00; reg_wr = 1'b0; reg_wdata = 16'h0000;
        rx_entry = 1'b0; tx_entry = 1'b0; transmit_calibrate_strobe = 1'b0; manual_gain_override = 1'b0;
        tuning_test_input_enable = 1'b0; osc_current_override_enable = 1'b0; cal_array_found = 5'h00;
        stage_removed = 1'b0; loop_gain = 7'h15; manual_gain = 7'h6a;
        mismatches = 0;
        total_checks = 0;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        // expected defaults are composed field by field
        reg_expect(6'h24, {4'h3, 6'h19, 6'h09}, "thresholds default");
        reg_expect(6'h25, {3'h0, 2'h1, 3'h0, 2'h1, 6'h14}, "tuning default");
        reg_expect(6'h26, {6'h00, 5'h09, 5'h0a}, "differences default");
        reg_expect(6'h27, {6'h00, 5'h10, 5'h10}, "array default");
        reg_expect(6'h28, {2'h1, 4'h4, 6'h00, 1'b0, 3'h2}, "control default");
        check_port({11'h0, osc_bank_applied}, 16'h0010, "array at reset");
        check_port({9'h0, gain_average_samples}, 16'h0010, "samples at reset");
        for (int i = 0; i < 5; i++) begin
            reg_write(6'h24 + i[5:0], ones_wr[i]);
            reg_expect(6'h24 + i[5:0], ones_exp[i], "all ones");
            reg_write(6'h24 + i[5:0], 16'h0000);
            reg_expect(6'h24 + i[5:0], (i == 3) ? 16'h0010 : 16'h0000, "all zeros");
        end
        reg_write(6'h29, 16'h1234);
        reg_expect(6'h29, 16'h0000, "unmapped");
        // a write while the enable is low must not land
        clk_en = 1'b0;
        reg_write(6'h26, 16'h0155);
        clk_en = 1'b1;
        reg_expect(6'h26, 16'h0000, "frozen write");
        for (int k = 0; k < 4; k++) begin
            reg_write(6'h25, {8'h00, k[1:0], 6'h14});
            repeat (2) @(negedge mclk);
            check_port({9'h0, gain_average_samples}, 16'h0008 << k, "window");
        end
        // every combination of override, blanking select and stage removal
        for (int i = 0; i < 8; i++) begin
            reg_write(6'h25, {1'b0, i[1], 14'h0854});
            manual_gain_override = i[2];
            stage_removed        = i[0];
            repeat (2) @(negedge mclk);
            check_port({15'h0, blank_now}, {15'h0, i[2] ? i[1] : (!i[1] && i[0])}, "blank");
            check_port({9'h0, applied_gain}, {9'h0, i[2] ? 7'h6a : 7'h15}, "gain");
        end
        manual_gain_override = 1'b0;
        reg_write(6'h27, {4'h0, 1'b1, 1'b1, 5'h0b, 5'h00});
        reg_write(6'h28, {2'h0, 4'h9, 6'h2d, 1'b1, 3'h5});
        osc_current_override_enable = 1'b1;
        repeat (2) @(negedge mclk);
        check_port({11'h0, osc_bank_applied}, 16'h000b, "array override");
        check_port({15'h0, osc_settle_extend}, 16'h0001, "settle extend");
        check_port({10'h0, current_override_b}, 16'h002d, "current b");
        check_port({15'h0, current_override_b_en}, 16'h0001, "current b enable");
        check_port({15'h0, tuning_from_converter}, 16'h0001, "tuning source");
        tuning_test_input_enable = 1'b1;
        repeat (2) @(negedge mclk);
        check_port({15'h0, tuning_from_converter}, 16'h0000, "tuning test input");
        tuning_test_input_enable = 1'b0;
        reg_write(6'h27, 16'h0000);
        reg_write(6'h28, 16'h5002);
        calibrate(0, 1'b1, 5'h07, n_long);
        reg_expect(6'h27, 16'h0007, "result after receive");
        check_port({11'h0, osc_bank_applied}, 16'h0007, "calibrated array");
        reg_write(6'h28, 16'h1002);
        calibrate(1, 1'b1, 5'h0c, n_short);
        calibrate(2, 1'b0, 5'h1e, n_tmp);
        reg_expect(6'h27, 16'h000c, "result kept");
        reg_write(6'h28, 16'h9002);
        calibrate(1, 1'b0, 5'h1e, n_tmp);
        calibrate(2, 1'b1, 5'h03, n_tmp);
        reg_write(6'h27, 16'h0800);
        calibrate(0, 1'b1, 5'h11, n_ext);
        reg_expect(6'h27, 16'h0811, "result with extend");
        // differences cancel the fixed request and reporting latency
        check_reg(16'(n_long - n_short), 16'(LONG_CYC - SHORT_CYC), "long minus short");
        check_reg(16'(n_ext - n_short), 16'(SHORT_CYC / 8), "extend minus short");
        // reset after the last calibration brings the result and the extend bit back to defaults
        @(negedge mclk);
        srst = 1'b1;
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        reg_expect(6'h27, 16'h0210, "array after reset");
        check_port({15'h0, osc_settle_extend}, 16'h0000, "extend after reset");
        report_and_stop();
    end
endmodule : agc_synth_test_regs_tb
